/* inc/als_cfg_pkg.sv */
// Register map, field positions and reset values of the light sensor config
package als_cfg_pkg;
  localparam logic [7:0] MAIN_GAIN_ADDR      = 8'h90;
  localparam logic [7:0] STATUS_ADDR         = 8'h93;
  localparam logic [7:0] GAIN_RANGE_ADDR     = 8'h9F;
  localparam logic [7:0] INT_SLEEP_ADDR      = 8'hAB;
  localparam logic [7:0] AUTOZERO_ADDR       = 8'hD6;
  localparam logic [7:0] INT_ENABLES_ADDR    = 8'hDD;
  localparam logic [7:0] VISIBLE_SCALE_ADDR  = 8'hE6;

  localparam logic [7:0] MAIN_GAIN_RESET     = 8'h00;
  localparam logic [7:0] GAIN_RANGE_RESET    = 8'h04;
  localparam logic [7:0] INT_SLEEP_RESET     = 8'h4C;
  localparam logic [7:0] AUTOZERO_RESET      = 8'h7F;
  localparam logic [7:0] INT_ENABLES_RESET   = 8'h00;
  localparam logic [7:0] STATUS_RESET        = 8'h00;

  localparam int GAIN_MAX_POS          = 4;
  localparam int GAIN_LOW_POS          = 2;
  localparam int CLEAR_ON_READ_POS     = 7;
  localparam int SLEEP_AFTER_INT_POS   = 4;
  localparam int SATURATION_FLAG_POS   = 7;
  localparam int LIGHT_FLAG_POS        = 4;
  localparam int CALIB_FLAG_POS        = 3;
  localparam int SATURATION_IEN_POS    = 7;
  localparam int LIGHT_IEN_POS         = 4;

  localparam logic [6:0] AUTOZERO_NEVER      = 7'h00;
  localparam logic [6:0] AUTOZERO_FIRST_ONLY = 7'h7F;
  localparam logic [7:0] UNMAPPED_READ       = 8'h00;
  localparam int BIT_COUNT_FULL              = 8;
endpackage : als_cfg_pkg

/* hdl/als_gain_sleep_autozero_config.sv */
// I2C register slave with gain, sleep, autozero and interrupt logic
`timescale 1ns/1ns
module als_gain_sleep_autozero_config #(
  parameter logic [6:0] DEVICE_ADDR   = 7'h39,
  parameter logic [7:0] VISIBLE_SCALE = 8'h80
) (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  output logic            int_out,
  output logic            int_oe_n,
  input  wire logic       power_on_bit,
  input  wire logic       light_threshold_event,
  input  wire logic       saturation_event,
  input  wire logic       calib_event,
  input  wire logic       meas_cycle_start,
  output logic            autozero_run,
  output logic [3:0]      gain_log2_x2,
  output logic            osc_enable
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WR_ACK, ST_RD, ST_RD_ACK
  } i2c_state_t;

  i2c_state_t state;
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic       scl_f;
  logic       sda_f;
  logic       scl_q;
  logic       sda_q;
  logic [7:0] shift_in;
  logic [7:0] rd_shift;
  logic [3:0] bit_cnt;
  logic [7:0] ptr;
  logic       rw;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic       status_rd;
  logic [7:0] main_gain;
  logic [7:0] gain_range;
  logic [7:0] int_sleep;
  logic [7:0] autozero_cfg;
  logic [7:0] int_enables;
  logic [7:0] status;
  logic       asleep;
  logic       first_done;
  logic [6:0] az_cnt;
  logic       int_active;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic [6:0] next_az_cnt;
  logic [7:0] rd_byte;

  function automatic logic [7:0] read_mux(input logic [7:0] a);
    if (a == als_cfg_pkg::MAIN_GAIN_ADDR) begin
      return main_gain;
    end else if (a == als_cfg_pkg::STATUS_ADDR) begin
      return status;
    end else if (a == als_cfg_pkg::GAIN_RANGE_ADDR) begin
      return gain_range;
    end else if (a == als_cfg_pkg::INT_SLEEP_ADDR) begin
      return int_sleep;
    end else if (a == als_cfg_pkg::AUTOZERO_ADDR) begin
      return autozero_cfg;
    end else if (a == als_cfg_pkg::INT_ENABLES_ADDR) begin
      return int_enables;
    end else if (a == als_cfg_pkg::VISIBLE_SCALE_ADDR) begin
      return VISIBLE_SCALE;
    end else begin
      return als_cfg_pkg::UNMAPPED_READ;
    end
  endfunction : read_mux

  // Readback byte for the current pointer
  always_comb begin
    rd_byte = read_mux(ptr);
  end

  // Pin synchronisers; a level counts once second and third stages agree
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_f    <= 1'b1;
      sda_f    <= 1'b1;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
      if (scl_sync[1] == scl_sync[2]) begin
        scl_f <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_f <= sda_sync[2];
      end
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  assign scl_rise   = scl_f & ~scl_q;
  assign scl_fall   = ~scl_f & scl_q;
  assign start_cond = scl_f & scl_q & sda_q & ~sda_f;
  assign stop_cond  = scl_f & scl_q & ~sda_q & sda_f;

  // I2C slave: write sets pointer then data, reads auto-increment
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state     <= ST_IDLE;
      shift_in  <= 8'h00;
      rd_shift  <= 8'h00;
      bit_cnt   <= 4'h0;
      ptr       <= 8'h00;
      rw        <= 1'b0;
      sda_oe_n  <= 1'b1;
      wr_en     <= 1'b0;
      wr_addr   <= 8'h00;
      wr_data   <= 8'h00;
      status_rd <= 1'b0;
    end else begin
      wr_en     <= 1'b0;
      status_rd <= 1'b0;
      if (start_cond) begin
        state    <= ST_ADDR;
        bit_cnt  <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_cond) begin
        state    <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
        case (state)
          ST_ADDR, ST_PTR, ST_WDATA: begin
            shift_in <= {shift_in[6:0], sda_f};
            bit_cnt  <= bit_cnt + 4'h1;
          end
          ST_RD: begin
            bit_cnt <= bit_cnt + 4'h1;
          end
          ST_RD_ACK: begin
            rw <= ~sda_f;  // Reused as master-acknowledged flag
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state)
          ST_ADDR: begin
            if (bit_cnt == 4'(als_cfg_pkg::BIT_COUNT_FULL)) begin
              if (shift_in[7:1] == DEVICE_ADDR) begin
                sda_oe_n <= 1'b0;
                rw       <= shift_in[0];
                state    <= ST_ADDR_ACK;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_PTR: begin
            if (bit_cnt == 4'(als_cfg_pkg::BIT_COUNT_FULL)) begin
              ptr      <= shift_in;
              sda_oe_n <= 1'b0;
              state    <= ST_PTR_ACK;
            end
          end
          ST_WDATA: begin
            if (bit_cnt == 4'(als_cfg_pkg::BIT_COUNT_FULL)) begin
              wr_en    <= 1'b1;
              wr_addr  <= ptr;
              wr_data  <= shift_in;
              ptr      <= ptr + 8'h01;
              sda_oe_n <= 1'b0;
              state    <= ST_WR_ACK;
            end
          end
          ST_PTR_ACK, ST_WR_ACK: begin
            sda_oe_n <= 1'b1;
            bit_cnt  <= 4'h0;
            state    <= ST_WDATA;
          end
          ST_ADDR_ACK, ST_RD_ACK: begin
            if ((state == ST_ADDR_ACK && !rw) ) begin
              sda_oe_n <= 1'b1;
              bit_cnt  <= 4'h0;
              state    <= ST_PTR;
            end else if (rw) begin
              // Byte is loaded here so clear-on-read follows a real read
              sda_oe_n  <= rd_byte[7];
              rd_shift  <= {rd_byte[6:0], 1'b0};
              status_rd <= (ptr == als_cfg_pkg::STATUS_ADDR);
              ptr       <= ptr + 8'h01;
              bit_cnt   <= 4'h0;
              state     <= ST_RD;
            end else begin
              sda_oe_n <= 1'b1;
              state    <= ST_IDLE;
            end
          end
          ST_RD: begin
            if (bit_cnt == 4'(als_cfg_pkg::BIT_COUNT_FULL)) begin
              sda_oe_n <= 1'b1;
              state    <= ST_RD_ACK;
            end else begin
              sda_oe_n <= rd_shift[7];
              rd_shift <= {rd_shift[6:0], 1'b0};
            end
          end
          default: begin
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // Configuration registers keep reserved bits as written
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      main_gain    <= als_cfg_pkg::MAIN_GAIN_RESET;
      gain_range   <= als_cfg_pkg::GAIN_RANGE_RESET;
      int_sleep    <= als_cfg_pkg::INT_SLEEP_RESET;
      autozero_cfg <= als_cfg_pkg::AUTOZERO_RESET;
      int_enables  <= als_cfg_pkg::INT_ENABLES_RESET;
    end else if (wr_en) begin
      if (wr_addr == als_cfg_pkg::MAIN_GAIN_ADDR) begin
        main_gain <= wr_data;
      end else if (wr_addr == als_cfg_pkg::GAIN_RANGE_ADDR) begin
        gain_range <= wr_data;
      end else if (wr_addr == als_cfg_pkg::INT_SLEEP_ADDR) begin
        int_sleep <= wr_data;
      end else if (wr_addr == als_cfg_pkg::AUTOZERO_ADDR) begin
        autozero_cfg <= wr_data;
      end else if (wr_addr == als_cfg_pkg::INT_ENABLES_ADDR) begin
        int_enables <= wr_data;
      end
    end
  end

  // Status flags; a new event beats a same-cycle clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      status <= als_cfg_pkg::STATUS_RESET;
    end else begin
      status <= (status
        & ~((wr_en && wr_addr == als_cfg_pkg::STATUS_ADDR)
            ? wr_data : 8'h00)
        & ~((status_rd && int_sleep[als_cfg_pkg::CLEAR_ON_READ_POS])
            ? 8'hFF : 8'h00))
        | (8'(light_threshold_event) << als_cfg_pkg::LIGHT_FLAG_POS)
        | (8'(saturation_event) << als_cfg_pkg::SATURATION_FLAG_POS)
        | (8'(calib_event) << als_cfg_pkg::CALIB_FLAG_POS);
    end
  end

  assign int_active =
    (status[als_cfg_pkg::LIGHT_FLAG_POS]
      & int_enables[als_cfg_pkg::LIGHT_IEN_POS])
    | (status[als_cfg_pkg::SATURATION_FLAG_POS]
      & int_enables[als_cfg_pkg::SATURATION_IEN_POS]);

  // Interrupt pin is open drain, low when active
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      int_out  <= 1'b0;
      sda_out  <= 1'b0;
      int_oe_n <= 1'b1;
    end else begin
      int_out  <= 1'b0;
      sda_out  <= 1'b0;
      int_oe_n <= ~int_active;
    end
  end

  // Sleep latch; disabling an enable does not wake, only clearing flags
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      asleep <= 1'b0;
    end else if (power_on_bit && int_sleep[als_cfg_pkg::SLEEP_AFTER_INT_POS]
                 && int_active) begin
      asleep <= 1'b1;
    end else if (!status[als_cfg_pkg::LIGHT_FLAG_POS]
                 && !status[als_cfg_pkg::SATURATION_FLAG_POS]) begin
      asleep <= 1'b0;
    end
  end

  // Power bit itself lives elsewhere and still reads back as set
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      osc_enable <= 1'b0;
    end else begin
      osc_enable <= power_on_bit && !asleep
        && !(int_sleep[als_cfg_pkg::SLEEP_AFTER_INT_POS] && int_active);
    end
  end

  // Gain as log2 of twice the factor: 0 is 1/2x, 8 is 128x
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gain_log2_x2 <= 4'h0;
    end else begin
      gain_log2_x2 <= {1'b0, main_gain[1:0], 1'b0}
        + 4'(gain_range[als_cfg_pkg::GAIN_LOW_POS])
        + 4'(gain_range[als_cfg_pkg::GAIN_MAX_POS]);
    end
  end

  assign next_az_cnt = (az_cnt + 7'h01 == autozero_cfg[6:0])
                       ? 7'h00 : az_cnt + 7'h01;

  // Autozero pacing restarts whenever power is removed
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      autozero_run <= 1'b0;
      first_done   <= 1'b0;
      az_cnt       <= 7'h00;
    end else if (!power_on_bit) begin
      autozero_run <= 1'b0;
      first_done   <= 1'b0;
      az_cnt       <= 7'h00;
    end else if (meas_cycle_start) begin
      first_done <= 1'b1;
      az_cnt     <= next_az_cnt;
      if (autozero_cfg[6:0] == als_cfg_pkg::AUTOZERO_NEVER) begin
        autozero_run <= 1'b0;
      end else if (autozero_cfg[6:0] == als_cfg_pkg::AUTOZERO_FIRST_ONLY) begin
        autozero_run <= !first_done;
      end else begin
        autozero_run <= (az_cnt == 7'h00);
      end
    end else begin
      autozero_run <= 1'b0;
    end
  end

endmodule : als_gain_sleep_autozero_config

/* testbench/als_cfg_chk.sv */
// Port-level assertions for the light sensor config block
`timescale 1ns/1ns
module als_cfg_chk (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       scl_in,
  input wire logic       sda_oe_n,
  input wire logic       int_oe_n,
  input wire logic       power_on_bit,
  input wire logic       light_threshold_event,
  input wire logic       saturation_event,
  input wire logic       meas_cycle_start,
  input wire logic       autozero_run,
  input wire logic [3:0] gain_log2_x2,
  input wire logic       osc_enable
);
  logic [3:0] idle;
  wire        bus = idle < 4'hC;
  // Register effects land a few cycles after an SCL fall
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      idle <= 4'h0;
    else if (!scl_in)
      idle <= 4'h0;
    else if (idle != 4'hF)
      idle <= idle + 4'h1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_az;
    meas_cycle_start ##1 autozero_run;
  endsequence
  AST_PON_OFF: assert property (!power_on_bit |=> !osc_enable)
    else $error("oscillator on while powered off");
  AST_PIN_SET: assert property ($fell(int_oe_n) |-> bus ||
    $past(light_threshold_event, 2) || $past(saturation_event, 2))
    else $error("interrupt pin set without cause");
  AST_PIN_CLR: assert property ($rose(int_oe_n) |-> bus)
    else $error("interrupt pin released without bus access");
  AST_AZ_CAUSE: assert property (autozero_run |->
    $past(meas_cycle_start))
    else $error("autozero without cycle start");
  AST_GAIN_MAX: assert property (gain_log2_x2 <= 4'h8)
    else $error("gain above top of range");
  AST_GAIN_BUS: assert property ($past(resetn, 2) &&
    $changed(gain_log2_x2) |-> bus)
    else $error("gain changed without register write");
  AST_WAKE: assert property ($past(resetn, 3) && $rose(osc_enable)
    |-> !$past(power_on_bit, 2) || bus)
    else $error("oscillator woke without flag clear");
  AST_SLEEP: assert property ($fell(osc_enable)
    |-> !$past(power_on_bit) || !int_oe_n)
    else $error("oscillator stopped without cause");
  AST_SDA_LOW: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data line changed while clock high");
  cover property (s_az);
endmodule : als_cfg_chk
bind als_gain_sleep_autozero_config als_cfg_chk u_chk (.ref_clk, .resetn,
  .scl_in, .sda_oe_n, .int_oe_n, .power_on_bit, .light_threshold_event,
  .saturation_event, .meas_cycle_start, .autozero_run, .gain_log2_x2,
  .osc_enable);

/* testbench/i2c_host_model.sv */
// I2C host model with register write and read tasks
`timescale 1ns/1ns
module i2c_host_model #(
  parameter logic [6:0] DEV = 7'h39
) (
  input  wire logic ref_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda
);
  logic [7:0] q;
  logic       k;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic hp;
    repeat (10) @(posedge ref_clk);
  endtask : hp
  // Data moves 3 cycles after SCL falls, keeping hold time
  task automatic bit_io(input logic b, output logic r);
    repeat (3) @(posedge ref_clk);
    sda <= b;
    hp();
    scl <= 1'b1;
    hp();
    r = sda_line;
    scl <= 1'b0;
  endtask : bit_io
  task automatic start;
    repeat (3) @(posedge ref_clk);
    sda <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda <= 1'b0;
    hp();
    scl <= 1'b0;
  endtask : start
  task automatic stop;
    repeat (3) @(posedge ref_clk);
    sda <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sda <= 1'b1;
    hp();
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic rel,
                      output logic [7:0] v, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      v[i] = r;
    end
    bit_io(rel, r);
    a = !r;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    xfer({DEV, 1'b0}, 1'b1, q, k);
    xfer(a, 1'b1, q, k);
    xfer(d, 1'b1, q, k);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    start();
    xfer({DEV, 1'b0}, 1'b1, q, k);
    xfer(a, 1'b1, q, k);
    start();
    xfer({DEV, 1'b1}, 1'b1, q, k);
    xfer(8'hFF, 1'b1, v, k);
    stop();
  endtask : rd
  // Software side correction, the device applies none
  function automatic logic [7:0] scaled(input logic [7:0] v,
                                        input logic [7:0] f);
    logic [15:0] m;
    m = {8'h00, v} * f[6:0] / 16'h0064;
    return f[7] ? v - m[7:0] : v + m[7:0];
  endfunction : scaled
endmodule : i2c_host_model

/* testbench/testbench.sv */
// Self-checking bench for the light sensor config block
`timescale 1ns/1ns
module testbench;
  typedef struct packed {
    logic [7:0] a;
    logic       w;
    logic [7:0] d;
    logic [7:0] e;
    logic [3:0] g;
  } row_t;
  logic       ref_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       power_on_bit = 1'b1;
  logic [2:0] ev = 3'h0;
  logic       mcs = 1'b0;
  logic [7:0] v;
  int         bad_count = 0;
  int         n_checks = 0;
  wire        scl, sda_h, sda_out, sda_oe_n, int_oe_n, az, osc;
  wire  [3:0] gain;
  // Pull-up wins unless a party pulls low
  wire        sda_line = sda_h & (sda_oe_n | sda_out);
  row_t rows [13] = '{
    '{8'h9F,1'h0,8'h00,8'h04,4'h1}, '{8'hAB,1'h0,8'h00,8'h4C,4'h1},
    '{8'hD6,1'h0,8'h00,8'h7F,4'h1}, '{8'hDD,1'h0,8'h00,8'h00,4'h1},
    '{8'hE6,1'h0,8'h00,8'h94,4'h1}, '{8'h50,1'h0,8'h00,8'h00,4'h1},
    '{8'h9F,1'h1,8'h00,8'h00,4'h0}, '{8'h9F,1'h1,8'h04,8'h04,4'h1},
    '{8'h90,1'h1,8'h01,8'h01,4'h3}, '{8'h90,1'h1,8'h02,8'h02,4'h5},
    '{8'h90,1'h1,8'h03,8'h03,4'h7}, '{8'h9F,1'h1,8'h14,8'h14,4'h8},
    '{8'hE6,1'h1,8'h55,8'h94,4'h8}};
  als_gain_sleep_autozero_config #(.VISIBLE_SCALE(8'h94)) u_dut (
    .ref_clk, .resetn, .scl_in(scl), .sda_in(sda_line), .sda_out,
    .sda_oe_n, .int_out(), .int_oe_n, .power_on_bit,
    .light_threshold_event(ev[0]), .saturation_event(ev[1]),
    .calib_event(ev[2]), .meas_cycle_start(mcs), .autozero_run(az),
    .gain_log2_x2(gain), .osc_enable(osc));
  i2c_host_model u_host (.ref_clk, .sda_line, .scl, .sda(sda_h));
  always #5 ref_clk = ~ref_clk;
  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk8
  task automatic chk1(input string n, input logic e, input logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask : chk1
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic pulse(input logic [2:0] m);
    @(posedge ref_clk);
    ev <= m;
    @(posedge ref_clk);
    ev <= 3'h0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : pulse
  task automatic power(input logic p);
    @(posedge ref_clk);
    power_on_bit <= p;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : power
  task automatic cyc(input logic e);
    @(posedge ref_clk);
    mcs <= 1'b1;
    @(posedge ref_clk);
    mcs <= 1'b0;
    #1 chk1("autozero", e, az);
  endtask : cyc
  task automatic do_reset;
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (5) @(posedge ref_clk);
  endtask : do_reset
  initial begin
    do_reset();
    foreach (rows[i]) begin
      if (rows[i].w)
        u_host.wr(rows[i].a, rows[i].d);
      u_host.rd(rows[i].a, v);
      chk8("register", rows[i].e, v);
      chk8("gain", {4'h0, rows[i].g}, {4'h0, gain});
    end
    chk8("scaled", 8'h50, u_host.scaled(8'h64, v));
    u_host.wr(8'hDD, 8'h10);
    pulse(3'h2);
    chk1("pin", 1'h1, int_oe_n);
    pulse(3'h1);
    chk1("pin", 1'h0, int_oe_n);
    chk1("osc", 1'h1, osc);
    u_host.rd(8'h93, v);
    chk8("status", 8'h90, v);
    u_host.wr(8'h93, 8'h90);
    chk1("pin", 1'h1, int_oe_n);
    u_host.wr(8'hAB, 8'hCC);
    pulse(3'h4);
    u_host.rd(8'h93, v);
    chk8("status", 8'h08, v);
    u_host.rd(8'h93, v);
    chk8("status", 8'h00, v);
    u_host.wr(8'hAB, 8'h5C);
    pulse(3'h1);
    chk1("osc", 1'h0, osc);
    u_host.wr(8'hDD, 8'h00);
    chk1("osc", 1'h0, osc);
    u_host.wr(8'h93, 8'h10);
    chk1("osc", 1'h1, osc);
    power(1'h0);
    chk1("osc", 1'h0, osc);
    power(1'h1);
    cyc(1'h1);
    cyc(1'h0);
    u_host.wr(8'hD6, 8'h02);
    power(1'h0);
    power(1'h1);
    for (int i = 0; i < 4; i++)
      cyc(i[0] == 1'b0);
    u_host.wr(8'hD6, 8'h00);
    power(1'h0);
    power(1'h1);
    cyc(1'h0);
    do_reset();
    u_host.rd(8'hD6, v);
    chk8("register", 8'h7F, v);
    chk8("gain", 8'h01, {4'h0, gain});
    summarize();
  end
  // Run needs about 26k cycles; 80k means a hang
  initial begin
    #800000;
    bad_count++;
    summarize();
  end
endmodule : testbench
